// [spp_pad_if.sv]
// Per-pin ownership signals between the port core and the pad multiplexers
`timescale 1ns/1ns
interface spp_pad_if #(parameter int WIDTH = 16);
   logic [WIDTH-1:0] port_dout;   // Output latch
   logic [WIDTH-1:0] port_oe;     // Port driver enable
   logic [WIDTH-1:0] per_own;     // Peripheral owns the pad
   logic [WIDTH-1:0] per_dout;    // Peripheral output data
   logic [WIDTH-1:0] pad_dout;    // Selected pad data
   logic [WIDTH-1:0] pad_oe;      // Selected pad enable
   modport core (output port_dout, port_oe, per_own, per_dout,
                 input  pad_dout, pad_oe);
   modport mux  (input  port_dout, port_oe, per_own, per_dout,
                 output pad_dout, pad_oe);
endinterface : spp_pad_if

// [spp_pad_model.sv]
// Behavioural model of the external circuitry on the shared pads
`timescale 1ns/1ns
module spp_pad_model (
   input  wire logic [15:0] pad_out,
   input  wire logic [15:0] pad_oe,
   input  wire logic [15:0] ext_drv,
   output logic      [15:0] pad_in
);
   // Device wins where it drives; the outside source sets every other pin
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_drv[i];
      end
   end
endmodule : spp_pad_model

// [spp_pad_mux.sv]
// Output data and output enable multiplexers of the pad cells
`timescale 1ns/1ns
module spp_pad_mux (
   spp_pad_if.mux pads
);
   // Peripheral wins both muxes while it owns the pin
   assign pads.pad_dout = (pads.per_own & pads.per_dout)
                        | (~pads.per_own & pads.port_dout);
   assign pads.pad_oe   = pads.per_own | pads.port_oe;
endmodule : spp_pad_mux

// [spp_pkg.sv]
// Shared constants for the shared parallel I/O port
package spp_pkg;
   localparam int          SPP_PORT_W    = 16;          // Pins in one port
   localparam int          SPP_ADDR_W    = 8;           // Bus address width
   localparam int          SPP_DATA_W    = 32;          // Bus data width
   // Register byte offsets
   localparam logic [7:0]  SPP_OFS_DIR   = 8'h00;       // pin_direction_bits
   localparam logic [7:0]  SPP_OFS_LEVEL = 8'h04;       // pin_level_bits
   localparam logic [7:0]  SPP_OFS_LATCH = 8'h08;       // output_latch_bits
   localparam logic [7:0]  SPP_OFS_ANSEL = 8'h0c;       // analog_pin_select
   // Reset values
   localparam logic [15:0] SPP_DIR_RST   = 16'hffff;    // All pins input
   localparam logic [15:0] SPP_LATCH_RST = 16'h0000;
   localparam logic [15:0] SPP_ANSEL_RST = 16'h0000;
   // Bus responses
   localparam logic [1:0]  SPP_RESP_OK   = 2'h0;
   localparam logic [1:0]  SPP_RESP_ERR  = 2'h2;
endpackage : spp_pkg

// [spp_port.sv]
// Shared parallel I/O port with AXI4-Lite register access
`timescale 1ns/1ns
module spp_port
   import spp_pkg::*;
#(
   parameter int                    WIDTH     = SPP_PORT_W,
   parameter logic [SPP_PORT_W-1:0] IMPL_MASK = 16'hffff, // Pins present
   parameter logic [SPP_PORT_W-1:0] PERI_OUT  = 16'hffff  // Peripheral can drive
) (
   input  wire logic                  CLK_SYS,
   input  wire logic                  RST_N,
   // AXI4-Lite slave
   input  wire logic [SPP_ADDR_W-1:0] AWADDR,
   input  wire logic                  AWVALID,
   output logic                       AWREADY,
   input  wire logic [SPP_DATA_W-1:0] WDATA,
   input  wire logic [3:0]            WSTRB,
   input  wire logic                  WVALID,
   output logic                       WREADY,
   output logic [1:0]                 BRESP,
   output logic                       BVALID,
   input  wire logic                  BREADY,
   input  wire logic [SPP_ADDR_W-1:0] ARADDR,
   input  wire logic                  ARVALID,
   output logic                       ARREADY,
   output logic [SPP_DATA_W-1:0]      RDATA,
   output logic [1:0]                 RRESP,
   output logic                       RVALID,
   input  wire logic                  RREADY,
   // Peripheral side
   input  wire logic [WIDTH-1:0]      PERIPH_EN,
   input  wire logic [WIDTH-1:0]      PERIPH_OE,
   input  wire logic [WIDTH-1:0]      PERIPH_DOUT,
   output logic [WIDTH-1:0]           PERIPH_DIN,
   output logic [WIDTH-1:0]           ANALOG_ROUTE,
   // Pads
   input  wire logic [WIDTH-1:0]      PAD_IN,
   output logic [WIDTH-1:0]           PAD_OUT,
   output logic [WIDTH-1:0]           PAD_OE
);
   localparam logic [WIDTH-1:0] IMPL = IMPL_MASK[WIDTH-1:0];

   logic             rst_meta_r;
   logic             rst_n;
   logic [WIDTH-1:0] dir_r;
   logic [WIDTH-1:0] latch_r;
   logic [WIDTH-1:0] ansel_r;
   logic [WIDTH-1:0] pad_sync;
   logic [WIDTH-1:0] pin_level_c;
   logic [WIDTH-1:0] own_c;
   logic             aw_held_r;
   logic             w_held_r;
   logic [SPP_ADDR_W-1:0] awaddr_r;
   logic [SPP_DATA_W-1:0] wdata_r;
   logic [3:0]       wstrb_r;
   logic             aw_held_nxt;
   logic             w_held_nxt;
   logic             do_wr;
   logic             ar_hs;
   logic             rvalid_nxt;

   spp_pad_if #(.WIDTH(WIDTH)) pads ();

   // Merge bus bytes into a register, honouring strobes
   function automatic logic [WIDTH-1:0] merge(
      input logic [WIDTH-1:0]      old,
      input logic [SPP_DATA_W-1:0] wd,
      input logic [3:0]            st);
      logic [WIDTH-1:0] res;
      res = old;
      for (int i = 0; i < WIDTH; i++) begin
         if (st[i/8]) begin
            res[i] = wd[i];
         end
      end
      return res;
   endfunction : merge

   // Is this a mapped register offset
   function automatic logic mapped(input logic [SPP_ADDR_W-1:0] a);
      return a == SPP_OFS_DIR || a == SPP_OFS_LEVEL ||
             a == SPP_OFS_LATCH || a == SPP_OFS_ANSEL;
   endfunction : mapped

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // Pad levels cross into the clock domain before any use
   spp_sync #(.WIDTH(WIDTH)) u_sync (
      .clk   (CLK_SYS),
      .rst_n (rst_n),
      .d     (PAD_IN),
      .q     (pad_sync)
   );

   // One level feeds both the peripheral and the read path
   assign pin_level_c = pad_sync & IMPL & ~ansel_r;
   // Input-only peripherals can never own a pin
   assign own_c = PERIPH_EN & PERIPH_OE & PERI_OUT[WIDTH-1:0]
                & IMPL;

   assign pads.port_dout = latch_r & IMPL;
   assign pads.port_oe   = ~dir_r & IMPL;
   assign pads.per_own   = own_c;
   assign pads.per_dout  = PERIPH_DOUT;

   spp_pad_mux u_mux (
      .pads (pads)
   );

   // Pad and peripheral outputs leave from flops
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         PAD_OUT      <= '0;
         PAD_OE       <= '0;
         PERIPH_DIN   <= '0;
         ANALOG_ROUTE <= '0;
      end else begin
         PAD_OUT      <= pads.pad_dout;
         PAD_OE       <= pads.pad_oe;
         PERIPH_DIN   <= pin_level_c;
         ANALOG_ROUTE <= ansel_r & IMPL;
      end
   end

   // Write channel bookkeeping; address and data may come in any order
   assign do_wr       = aw_held_r & w_held_r & ~BVALID;
   assign aw_held_nxt = do_wr ? 1'b0 : (aw_held_r | (AWVALID & AWREADY));
   assign w_held_nxt  = do_wr ? 1'b0 : (w_held_r | (WVALID & WREADY));

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         AWREADY   <= 1'b0;
         WREADY    <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r  <= w_held_nxt;
         AWREADY   <= ~aw_held_nxt;
         WREADY    <= ~w_held_nxt;
         if (AWVALID && AWREADY) begin
            awaddr_r <= AWADDR;
         end
         if (WVALID && WREADY) begin
            wdata_r <= WDATA;
            wstrb_r <= WSTRB;
         end
      end
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         BVALID <= 1'b0;
         BRESP  <= SPP_RESP_OK;
      end else if (do_wr) begin
         BVALID <= 1'b1;
         BRESP  <= mapped(awaddr_r) ? SPP_RESP_OK : SPP_RESP_ERR;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // Direction register; unimplemented bits held as inputs
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         dir_r <= SPP_DIR_RST[WIDTH-1:0];
      end else if (do_wr && awaddr_r == SPP_OFS_DIR) begin
         dir_r <= merge(dir_r, wdata_r, wstrb_r) | ~IMPL;
      end
   end

   // Latch takes writes through either the latch or the level address
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         latch_r <= SPP_LATCH_RST[WIDTH-1:0];
      end else if (do_wr && (awaddr_r == SPP_OFS_LATCH ||
                             awaddr_r == SPP_OFS_LEVEL)) begin
         latch_r <= merge(latch_r, wdata_r, wstrb_r) & IMPL;
      end
   end

   // Analog selection; software must also leave those pins as inputs
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ansel_r <= SPP_ANSEL_RST[WIDTH-1:0];
      end else if (do_wr && awaddr_r == SPP_OFS_ANSEL) begin
         ansel_r <= merge(ansel_r, wdata_r, wstrb_r) & IMPL;
      end
   end

   // Read channel; one read in flight, data one cycle after address
   assign ar_hs      = ARVALID & ARREADY;
   assign rvalid_nxt = ar_hs | (RVALID & ~RREADY);

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= '0;
         RRESP   <= SPP_RESP_OK;
      end else begin
         ARREADY <= ~rvalid_nxt;
         RVALID  <= rvalid_nxt;
         if (ar_hs) begin
            RRESP <= mapped(ARADDR) ? SPP_RESP_OK : SPP_RESP_ERR;
            unique case (ARADDR)
               SPP_OFS_DIR:   RDATA <= 32'(dir_r & IMPL);
               SPP_OFS_LEVEL: RDATA <= 32'(pin_level_c);
               SPP_OFS_LATCH: RDATA <= 32'(latch_r & IMPL);
               SPP_OFS_ANSEL: RDATA <= 32'(ansel_r & IMPL);
               default:       RDATA <= '0;
            endcase
         end
      end
   end

   // Checks on the pad muxes and register paths
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!rst_n);

   a_reset_inputs: assert property (
      !$past(rst_n) |-> (dir_r == SPP_DIR_RST[WIDTH-1:0]) && (PAD_OE == 0))
      else $error("Pins not inputs after reset");

   // Pads are still in reset at the release edge, so start one edge later
   a_periph_owns: assert property (
      rst_n |=> ((PAD_OUT ^ $past(PERIPH_DOUT)) & $past(own_c)) == 0
               && (PAD_OE & $past(own_c)) == $past(own_c))
      else $error("Owning peripheral not on pad");

   a_port_enable: assert property (
      1'b1 |=> ((PAD_OE ^ ~$past(dir_r)) & ~$past(own_c) & IMPL) == 0)
      else $error("Port enable wrong on free pin");

   a_port_data: assert property (
      1'b1 |=> ((PAD_OUT ^ $past(latch_r)) & ~$past(own_c) & IMPL) == 0)
      else $error("Port data wrong on free pin");

   // Input-only peripheral pins follow direction and latch alone
   a_input_only: assert property (
      rst_n |=> ((PAD_OE ^ ~$past(dir_r)) & ~PERI_OUT[WIDTH-1:0] & IMPL) == 0
               && ((PAD_OUT ^ $past(latch_r)) & ~PERI_OUT[WIDTH-1:0]
                   & IMPL) == 0)
      else $error("Input-only pin left port control");

   a_dir_written: assert property (
      do_wr && awaddr_r == SPP_OFS_DIR && wstrb_r == 4'hf
      |=> dir_r == ($past(wdata_r[WIDTH-1:0]) | ~IMPL))
      else $error("Direction write lost");

   a_latch_read: assert property (
      ar_hs && ARADDR == SPP_OFS_LATCH
      |=> RVALID && RDATA == 32'($past(latch_r) & IMPL))
      else $error("Latch read wrong");

   a_level_read: assert property (
      ar_hs && ARADDR == SPP_OFS_LEVEL |=> RDATA == 32'($past(pin_level_c)))
      else $error("Level read wrong");

   a_level_write: assert property (
      do_wr && awaddr_r == SPP_OFS_LEVEL && wstrb_r == 4'hf
      |=> latch_r == ($past(wdata_r[WIDTH-1:0]) & IMPL) && BVALID)
      else $error("Level write missed the latch");

   a_unimpl_zero: assert property (
      ((PAD_OE | PERIPH_DIN | ANALOG_ROUTE) & ~IMPL) == 0)
      else $error("Unimplemented pin active");

   a_analog_zero: assert property (
      1'b1 |=> (PERIPH_DIN & $past(ansel_r)) == 0)
      else $error("Analog pin reads high");

   a_digital_route: assert property (
      1'b1 |=> (ANALOG_ROUTE & ~$past(ansel_r)) == 0)
      else $error("Digital pin routed to converter");

   a_same_level: assert property (
      ar_hs && ARADDR == SPP_OFS_LEVEL |=> RDATA == 32'(PERIPH_DIN))
      else $error("Peripheral and read path differ");

   c_periph_owns: cover property (own_c != 0 ##1 PAD_OE != 0);
   c_level_write: cover property (do_wr && awaddr_r == SPP_OFS_LEVEL);
   c_level_read:  cover property (ar_hs && ARADDR == SPP_OFS_LEVEL);
endmodule : spp_port

// [spp_port_tb.sv]
// Self-checking testbench of the shared parallel I/O port
`timescale 1ns/1ns
module spp_port_tb;
   import spp_pkg::*;
   localparam logic [15:0] IMPL = 16'hbfff;   // Pin 14 absent
   localparam logic [15:0] PERI = 16'h7fff;   // Pin 15 input-only peripheral
   logic        clk = 1'b0, rst_n = 1'b0;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0;
   logic [3:0]  wstrb = '0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] en = '0, oe = '0, pd = '0, ext = '0;
   logic [15:0] din, aroute, pad_in, pad_out, pad_oe;
   int          err_count = 0, num_checks = 0, tick = 0;
   logic [15:0] d, l, a;
   logic [31:0] rd;
   logic [1:0]  rs;

   always #5 clk = ~clk;

   spp_port #(.IMPL_MASK(IMPL), .PERI_OUT(PERI)) dut (
      .CLK_SYS(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
      .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .PERIPH_EN(en),
      .PERIPH_OE(oe), .PERIPH_DOUT(pd), .PERIPH_DIN(din),
      .ANALOG_ROUTE(aroute), .PAD_IN(pad_in), .PAD_OUT(pad_out),
      .PAD_OE(pad_oe));

   spp_pad_model pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_drv(ext),
                       .pad_in(pad_in));

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // Cuts a hung handshake short; the whole run needs a few hundred cycles
   always @(posedge clk) begin
      tick++;
      if (tick == 20000) begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_resp

   // Offers address and data together, drops each once it is taken
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt,
                         input logic [3:0] st, output logic [1:0] resp);
      bit aw_on, w_on;
      aw_on = 1;
      w_on = 1;
      @(posedge clk);
      awaddr <= ad; awvalid <= 1'b1; wdata <= dt; wstrb <= st;
      wvalid <= 1'b1; bready <= 1'b1;
      while (aw_on || w_on) begin
         @(posedge clk);
         if (aw_on && awready === 1'b1) begin aw_on = 0; awvalid <= 1'b0; end
         if (w_on && wready === 1'b1) begin w_on = 0; wvalid <= 1'b0; end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt,
                         output logic [1:0] resp);
      @(posedge clk);
      araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      dt = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   // Reads one register and compares the word and an OKAY response
   task automatic rd_chk(input logic [7:0] ad, input logic [15:0] exp);
      axi_rd(ad, rd, rs);
      chk_val(rd, {16'h0000, exp});
      chk_resp(rs, SPP_RESP_OK);
   endtask : rd_chk

   function automatic logic [15:0] own_f(input logic [15:0] e, o);
      return e & o & PERI & IMPL;
   endfunction : own_f

   // Pad enable and data the port should drive
   function automatic logic [15:0] oe_f(input logic [15:0] dr);
      return (own_f(en, oe) | ~dr) & IMPL;
   endfunction : oe_f

   function automatic logic [15:0] out_f(input logic [15:0] lt);
      return (own_f(en, oe) & pd) | (~own_f(en, oe) & lt & IMPL);
   endfunction : out_f

   // Pad level the port should report: present, digital pins only
   function automatic logic [15:0] lvl_f(input logic [15:0] dr, lt, an);
      logic [15:0] pe;
      pe = oe_f(dr);
      return ((pe & out_f(lt)) | (~pe & ext)) & IMPL & ~an;
   endfunction : lvl_f

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk_val(32'(pad_oe), 32'h0000_0000);
      rst_n <= 1'b1;
      rd_chk(SPP_OFS_DIR, SPP_DIR_RST & IMPL);
      rd_chk(SPP_OFS_LATCH, SPP_LATCH_RST);
      rd_chk(SPP_OFS_ANSEL, SPP_ANSEL_RST);
   endtask : do_reset

   initial begin
      void'($urandom(32'he86ada73));
      do_reset();
      $display("test reset done");
      for (int n = 0; n < 16; n++) begin
         d = (n == 0) ? 16'h0000 : 16'($urandom);
         l = 16'($urandom);
         a = (n < 2) ? 16'h0000 : 16'($urandom) & IMPL;
         d = d | a;
         @(posedge clk);
         en <= (n < 2) ? 16'hffff : 16'($urandom);
         oe <= (n == 0) ? 16'hffff : (n == 1) ? 16'h0000 : 16'($urandom);
         pd <= 16'($urandom);
         ext <= 16'($urandom);
         axi_wr(SPP_OFS_DIR, {16'($urandom), d}, 4'hf, rs);
         chk_resp(rs, SPP_RESP_OK);
         axi_wr(n[0] ? SPP_OFS_LEVEL : SPP_OFS_LATCH, {16'h0, l}, 4'hf, rs);
         chk_resp(rs, SPP_RESP_OK);
         axi_wr(SPP_OFS_ANSEL, {16'h0, a}, 4'hf, rs);
         chk_resp(rs, SPP_RESP_OK);
         repeat (4) @(posedge clk);
         chk_val(32'(pad_oe), 32'(oe_f(d)));
         chk_val(32'(pad_out), 32'(out_f(l)));
         chk_val(32'(din), 32'(lvl_f(d, l, a)));
         chk_val(32'(aroute), 32'(a));
         rd_chk(SPP_OFS_DIR, d & IMPL);
         rd_chk(SPP_OFS_LATCH, l & IMPL);
         rd_chk(SPP_OFS_LEVEL, lvl_f(d, l, a));
         rd_chk(SPP_OFS_ANSEL, a);
      end
      $display("test pin ownership done");
      // Only the low byte strobe is set, so the high latch byte must hold
      axi_wr(SPP_OFS_LATCH, 32'h0000_5a5a, 4'h1, rs);
      rd_chk(SPP_OFS_LATCH, {l[15:8], 8'h5a} & IMPL);
      axi_wr(8'h10, 32'h0000_ffff, 4'hf, rs);
      chk_resp(rs, SPP_RESP_ERR);
      // An unmapped write must leave the latch alone
      rd_chk(SPP_OFS_LATCH, {l[15:8], 8'h5a} & IMPL);
      axi_rd(8'h10, rd, rs);
      chk_val(rd, 32'h0000_0000);
      chk_resp(rs, SPP_RESP_ERR);
      $display("test strobe and unmapped done");
      do_reset();
      $display("test second reset done");
      report_and_stop();
   end
endmodule : spp_port_tb

// [spp_sync.sv]
// Two flip-flop synchroniser for pad levels
`timescale 1ns/1ns
module spp_sync #(parameter int WIDTH = 16) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : spp_sync
